/* File: hdl/dsim_core.sv */
/*
 * Device-side core of a quad-bank DDR SDRAM: command decode, mode and extended
 * mode registers, bank/row tracking, init sequence tracking, burst addressing
 * and a small storage array behind double-rate data pins.
 * Assumes the controller drives commands and data synchronously to ref_clk_in;
 * each clock carries one 2n-bit word split into rise and fall halves.
 */
`timescale 1ns/1ps

// Behaviour
// - each clock moves one 2n-bit core word as two n-bit pin halves
// - Active picks bank from bank bits and opens the row on address
// - Read/Write address gives the starting column within the open row
// - data and strobe outputs stay undriven until a read drives them
// - Precharge ALL after lock leaves all banks idle
// - mode set with bank bits 00 loads the mode register and keeps it
// - the DLL reset bit clears itself after use
// - fields: length A0-A2, type A3, latency A4-A6, mode A7-A12
// - burst lengths 2, 4, 8 for both types; code 010 is four
// - latency code 010 is two clocks, 101 is two and a half
// - bursts wrap inside an aligned block equal to the burst length
// - one burst length governs reads and writes
// - sequential order increments the low bits modulo burst length
// - interleaved order XORs the low start bits with the beat count
// - all-zero operating mode is normal, other non-reset patterns reserved
// - A8 alone requests DLL reset, later followed by a normal write
// - read data appears m clocks after the Read edge; latency code 101 (two and a half) gives three clocks
// - bank bits 01 load the extended register; bit zero low enables DLL
module dsim_core
(
	input  wire logic               ref_clk_in,       // 40 MHz clock
	input  wire logic               reset_n_in,       // async reset, active low
	input  wire dsim_pkg::dsim_cmd_s cmd_in,          // command, bank and address pins
	input  wire dsim_pkg::dsim_pair_s dq_in,          // write data halves
	input  wire logic [1:0]         dm_in,            // write mask {rise, fall}
	input  wire logic               rd_stall_in,      // receiver holds off read data
	output logic                    rd_ready_out,     // read buffer can take a word
	output dsim_pkg::dsim_pair_s    dq_out,           // read data halves
	output logic                    dq_oe_out,        // high while driving data
	output logic [1:0]              dqs_out,          // read strobe {rise, fall}
	output logic                    dqs_oe_out,       // high while driving strobe
	output logic [12:0]             mode_cfg_out,     // mode register contents
	output logic                    dll_on_out,       // DLL enabled and locked
	output logic                    init_done_out,    // init sequence complete
	output logic                    cfg_reserved_out  // reserved code in mode register
);

	localparam int BUF_DEPTH = 2;

	// short local names for the package's state codes, nothing is imported
	localparam dsim_pkg::dsim_burst_e BST_IDLE    = dsim_pkg::BST_IDLE;
	localparam dsim_pkg::dsim_burst_e BST_RD_WAIT = dsim_pkg::BST_RD_WAIT;
	localparam dsim_pkg::dsim_burst_e BST_RD      = dsim_pkg::BST_RD;
	localparam dsim_pkg::dsim_burst_e BST_WR      = dsim_pkg::BST_WR;
	localparam dsim_pkg::dsim_init_e  INI_PRE1    = dsim_pkg::INI_PRE1;
	localparam dsim_pkg::dsim_init_e  INI_EXT     = dsim_pkg::INI_EXT;
	localparam dsim_pkg::dsim_init_e  INI_DLLRST  = dsim_pkg::INI_DLLRST;
	localparam dsim_pkg::dsim_init_e  INI_LOCK    = dsim_pkg::INI_LOCK;
	localparam dsim_pkg::dsim_init_e  INI_PRE2    = dsim_pkg::INI_PRE2;
	localparam dsim_pkg::dsim_init_e  INI_REF1    = dsim_pkg::INI_REF1;
	localparam dsim_pkg::dsim_init_e  INI_REF2    = dsim_pkg::INI_REF2;
	localparam dsim_pkg::dsim_init_e  INI_MODE    = dsim_pkg::INI_MODE;
	localparam dsim_pkg::dsim_init_e  INI_DONE    = dsim_pkg::INI_DONE;

	// state
	dsim_pkg::dsim_burst_e burst_reg, burst_next;
	dsim_pkg::dsim_init_e  init_reg, init_next;
	logic [12:0]          mode_reg, mode_next;
	logic [12:0]          ext_reg, ext_next;
	logic [12:0]          row_reg [4];
	logic [12:0]          row_next [4];
	logic [3:0]           open_reg, open_next;
	logic [1:0]           bank_reg, bank_next;
	logic [3:0]           start_reg, start_next;
	logic [2:0]           beat_reg, beat_next;
	logic [7:0]           lock_reg, lock_next;
	logic                 locked_reg, locked_next;
	logic                 rsv_reg, rsv_next;

	// read buffer and pin stage
	logic [2*dsim_pkg::DQ_W-1:0] buf_reg [BUF_DEPTH];
	logic [2*dsim_pkg::DQ_W-1:0] buf_next [BUF_DEPTH];
	logic                 wptr_reg, wptr_next;
	logic                 rptr_reg, rptr_next;
	logic [1:0]           cnt_reg, cnt_next;
	dsim_pkg::dsim_pair_s dq_reg, dq_next;
	logic                 oe_reg, oe_next;

	logic [2*dsim_pkg::DQ_W-1:0] mem [256];

	// decode
	logic [3:0]           cmd;
	logic                 cmd_ok;
	logic                 bl_ok;
	logic                 cl_ok;
	logic [2:0]           last_beat;
	logic                 lat_extra;
	logic                 rd_take;
	logic                 wr_take;
	logic                 push;
	logic                 pop;
	logic [3:0]           cur_col;
	logic [7:0]           mem_idx;
	logic [5:0]           opmode;

	// burst column for beat k: block bits kept, low bits wrap by length
	function automatic logic [3:0] col_of(input logic [3:0] start, input logic [2:0] k,
		input logic [2:0] bl_code, input logic ilv);
		logic [3:0] mask;
		logic [3:0] low;
		mask = 4'h7;
		low  = 4'h0;
		if (bl_code == dsim_pkg::BL_CODE_2)
		begin
			mask = 4'h1;
		end
		else if (bl_code == dsim_pkg::BL_CODE_4)
		begin
			mask = 4'h3;
		end
		if (ilv)
		begin
			low = start ^ {1'b0, k};
		end
		else
		begin
			low = start + {1'b0, k};
		end
		return (start & ~mask) | (low & mask);
	endfunction

	always_comb
	begin
		cmd       = {cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
		cmd_ok    = cmd_in.cke && !cmd_in.cs_n;
		opmode    = mode_reg[12:dsim_pkg::OPMODE_LSB];
		bl_ok     = 1'b1;
		last_beat = 3'h7;
		unique case (mode_reg[dsim_pkg::BL_LSB +: 3])
			dsim_pkg::BL_CODE_2: last_beat = 3'h1;
			dsim_pkg::BL_CODE_4: last_beat = 3'h3;
			dsim_pkg::BL_CODE_8: last_beat = 3'h7;
			default:             bl_ok     = 1'b0;
		endcase
		cl_ok     = 1'b1;
		lat_extra = 1'b1;
		unique case (mode_reg[dsim_pkg::CL_LSB +: 3])
			dsim_pkg::CL_CODE_2:  lat_extra = 1'b0;
			dsim_pkg::CL_CODE_25: lat_extra = 1'b1;
			dsim_pkg::CL_CODE_3:  lat_extra = 1'b1;
			default:              cl_ok     = 1'b0;
		endcase
		// reserved length codes refuse reads and writes, reserved latency codes refuse reads only, reserved operating modes refuse neither
		rd_take = cmd_ok && cmd == dsim_pkg::CMD_RD && burst_reg == BST_IDLE
			&& bl_ok && cl_ok && open_reg[cmd_in.ba];
		wr_take = cmd_ok && cmd == dsim_pkg::CMD_WR && burst_reg == BST_IDLE
			&& bl_ok && open_reg[cmd_in.ba];
		cur_col = col_of(start_reg, beat_reg, mode_reg[dsim_pkg::BL_LSB +: 3],
			mode_reg[dsim_pkg::BT_BIT]);
		mem_idx = {bank_reg, row_reg[bank_reg][1:0], cur_col};
		push    = burst_reg == BST_RD && cnt_reg < 2'(BUF_DEPTH);
		pop     = cnt_reg != 2'h0 && !rd_stall_in;
	end

	// command, mode and burst control
	always_comb
	begin
		burst_next  = burst_reg;
		mode_next   = mode_reg;
		ext_next    = ext_reg;
		open_next   = open_reg;
		bank_next   = bank_reg;
		start_next  = start_reg;
		beat_next   = beat_reg;
		for (int b = 0; b < 4; b++)
		begin
			row_next[b] = row_reg[b];
		end
		mode_next[dsim_pkg::DLL_RST_BIT] = 1'b0;
		if (cmd_ok && cmd == dsim_pkg::CMD_ACT)
		begin
			row_next[cmd_in.ba]  = cmd_in.addr;
			open_next[cmd_in.ba] = 1'b1;
		end
		if (cmd_ok && cmd == dsim_pkg::CMD_PRE)
		begin
			if (cmd_in.addr[dsim_pkg::PRE_ALL_BIT])
			begin
				open_next = 4'h0;
			end
			else
			begin
				open_next[cmd_in.ba] = 1'b0;
			end
		end
		// mode writes are honoured only with no burst running and banks idle
		if (cmd_ok && cmd == dsim_pkg::CMD_MRS && burst_reg == BST_IDLE && open_reg == 4'h0)
		begin
			if (cmd_in.ba == dsim_pkg::BA_MODE)
			begin
				mode_next = cmd_in.addr;
			end
			else if (cmd_in.ba == dsim_pkg::BA_EXT_MODE)
			begin
				ext_next = cmd_in.addr;
			end
		end
		unique case (burst_reg)
			BST_IDLE:
			begin
				if (rd_take || wr_take)
				begin
					bank_next  = cmd_in.ba;
					start_next = cmd_in.addr[dsim_pkg::COL_W-1:0];
					beat_next  = 3'h0;
					if (wr_take)
					begin
						burst_next = BST_WR;
					end
					else if (lat_extra)
					begin
						burst_next = BST_RD_WAIT;
					end
					else
					begin
						burst_next = BST_RD;
					end
				end
			end
			BST_RD_WAIT:
			begin
				burst_next = BST_RD;
			end
			BST_RD:
			begin
				if (push)
				begin
					beat_next = beat_reg + 3'h1;
					if (beat_reg == last_beat)
					begin
						burst_next = BST_IDLE;
					end
				end
			end
			BST_WR:
			begin
				beat_next = beat_reg + 3'h1;
				if (beat_reg == last_beat)
				begin
					burst_next = BST_IDLE;
				end
			end
		endcase
	end

	// init sequence tracking and DLL lock count
	always_comb
	begin
		init_next   = init_reg;
		lock_next   = lock_reg;
		locked_next = locked_reg;
		rsv_next    = !bl_ok || !cl_ok
			|| (opmode != dsim_pkg::OPMODE_NORMAL && opmode != dsim_pkg::OPMODE_DLLRST);
		if (ext_reg[dsim_pkg::EXT_DLL_BIT])
		begin
			locked_next = 1'b0;
		end
		if (mode_reg[dsim_pkg::DLL_RST_BIT])
		begin
			lock_next   = dsim_pkg::DLL_LOCK_CYC;
			locked_next = 1'b0;
		end
		else if (lock_reg != 8'h00)
		begin
			lock_next = lock_reg - 8'h01;
			if (lock_reg == 8'h01 && !ext_reg[dsim_pkg::EXT_DLL_BIT])
			begin
				locked_next = 1'b1;
			end
		end
		if (cmd_ok)
		begin
			unique case (init_reg)
				INI_PRE1:
				begin
					if (cmd == dsim_pkg::CMD_PRE && cmd_in.addr[dsim_pkg::PRE_ALL_BIT])
					begin
						init_next = INI_EXT;
					end
				end
				INI_EXT:
				begin
					if (cmd == dsim_pkg::CMD_MRS && cmd_in.ba == dsim_pkg::BA_EXT_MODE
						&& !cmd_in.addr[dsim_pkg::EXT_DLL_BIT])
					begin
						init_next = INI_DLLRST;
					end
				end
				INI_DLLRST:
				begin
					if (cmd == dsim_pkg::CMD_MRS && cmd_in.ba == dsim_pkg::BA_MODE
						&& cmd_in.addr[dsim_pkg::DLL_RST_BIT])
					begin
						init_next = INI_LOCK;
					end
				end
				INI_LOCK:
				begin
					// a command during lock restarts the sequence
					init_next = INI_PRE1;
				end
				INI_PRE2:
				begin
					if (cmd == dsim_pkg::CMD_PRE && cmd_in.addr[dsim_pkg::PRE_ALL_BIT])
					begin
						init_next = INI_REF1;
					end
				end
				INI_REF1:
				begin
					if (cmd == dsim_pkg::CMD_REF)
					begin
						init_next = INI_REF2;
					end
				end
				INI_REF2:
				begin
					if (cmd == dsim_pkg::CMD_REF)
					begin
						init_next = INI_MODE;
					end
				end
				INI_MODE:
				begin
					if (cmd == dsim_pkg::CMD_MRS && cmd_in.ba == dsim_pkg::BA_MODE
						&& !cmd_in.addr[dsim_pkg::DLL_RST_BIT])
					begin
						init_next = INI_DONE;
					end
				end
				INI_DONE:
				begin
					init_next = INI_DONE;
				end
			endcase
		end
		if (init_reg == INI_LOCK && !cmd_ok && lock_reg == 8'h01)
		begin
			init_next = INI_PRE2;
		end
	end

	// read buffer and pin stage: a stalled receiver backs the burst up
	always_comb
	begin
		buf_next[0] = buf_reg[0];
		buf_next[1] = buf_reg[1];
		wptr_next   = wptr_reg;
		rptr_next   = rptr_reg;
		cnt_next    = cnt_reg;
		dq_next     = dq_reg;
		oe_next     = pop;
		if (push)
		begin
			buf_next[wptr_reg] = mem[mem_idx];
			wptr_next          = !wptr_reg;
		end
		if (pop)
		begin
			dq_next   = buf_reg[rptr_reg];
			rptr_next = !rptr_reg;
		end
		cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			burst_reg  <= BST_IDLE;
			init_reg   <= INI_PRE1;
			mode_reg   <= dsim_pkg::MODE_RESET;
			ext_reg    <= dsim_pkg::EXT_RESET;
			open_reg   <= 4'h0;
			bank_reg   <= 2'h0;
			start_reg  <= 4'h0;
			beat_reg   <= 3'h0;
			lock_reg   <= 8'h00;
			locked_reg <= 1'b0;
			rsv_reg    <= 1'b0;
			wptr_reg   <= 1'b0;
			rptr_reg   <= 1'b0;
			cnt_reg    <= 2'h0;
			dq_reg     <= '0;
			oe_reg     <= 1'b0;
			for (int b = 0; b < 4; b++)
			begin
				row_reg[b] <= 13'h0000;
			end
			buf_reg[0] <= '0;
			buf_reg[1] <= '0;
		end
		else
		begin
			burst_reg  <= burst_next;
			init_reg   <= init_next;
			mode_reg   <= mode_next;
			ext_reg    <= ext_next;
			open_reg   <= open_next;
			bank_reg   <= bank_next;
			start_reg  <= start_next;
			beat_reg   <= beat_next;
			lock_reg   <= lock_next;
			locked_reg <= locked_next;
			rsv_reg    <= rsv_next;
			wptr_reg   <= wptr_next;
			rptr_reg   <= rptr_next;
			cnt_reg    <= cnt_next;
			dq_reg     <= dq_next;
			oe_reg     <= oe_next;
			for (int b = 0; b < 4; b++)
			begin
				row_reg[b] <= row_next[b];
			end
			buf_reg[0] <= buf_next[0];
			buf_reg[1] <= buf_next[1];
		end
	end

	// write halves land in one core word per clock, masked per half
	always_ff @(posedge ref_clk_in)
	begin
		if (burst_reg == BST_WR)
		begin
			if (!dm_in[1])
			begin
				mem[mem_idx][2*dsim_pkg::DQ_W-1:dsim_pkg::DQ_W] <= dq_in.rise;
			end
			if (!dm_in[0])
			begin
				mem[mem_idx][dsim_pkg::DQ_W-1:0] <= dq_in.fall;
			end
		end
	end

	assign rd_ready_out     = cnt_reg < 2'(BUF_DEPTH);
	assign dq_out           = dq_reg;
	assign dq_oe_out        = oe_reg;
	assign dqs_out          = 2'h2;
	assign dqs_oe_out       = oe_reg;
	assign mode_cfg_out     = mode_reg;
	assign dll_on_out       = locked_reg;
	assign init_done_out    = init_reg == INI_DONE;
	assign cfg_reserved_out = rsv_reg;

	chk_mode_load: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		cmd_ok && cmd == dsim_pkg::CMD_MRS && cmd_in.ba == dsim_pkg::BA_MODE
		&& burst_reg == BST_IDLE && open_reg == 4'h0
		|=> mode_reg[7:0] == $past(cmd_in.addr[7:0]) && mode_reg[12:9] == $past(cmd_in.addr[12:9]))
		else $error("mode register did not load");

	chk_dll_selfclear: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		mode_reg[dsim_pkg::DLL_RST_BIT] |=> !mode_reg[dsim_pkg::DLL_RST_BIT]
		|| $past(cmd_ok && cmd == dsim_pkg::CMD_MRS))
		else $error("DLL reset bit did not clear");

	chk_ext_load: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		cmd_ok && cmd == dsim_pkg::CMD_MRS && cmd_in.ba == dsim_pkg::BA_EXT_MODE
		&& burst_reg == BST_IDLE && open_reg == 4'h0 |=> ext_reg == $past(cmd_in.addr))
		else $error("extended register did not load");

	chk_pins_quiet: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		dq_oe_out |-> $past(cnt_reg) != 2'h0)
		else $error("data driven without read data");

	chk_read_latency: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		rd_take && !lat_extra ##2 !rd_stall_in |=> dq_oe_out)
		else $error("read data late for latency two");

	chk_burst_block: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		burst_reg == BST_RD && mode_reg[2:0] == dsim_pkg::BL_CODE_4
		|-> cur_col[3:2] == start_reg[3:2])
		else $error("burst left its block");

	chk_order_seq: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		burst_reg == BST_WR && !mode_reg[dsim_pkg::BT_BIT]
		&& mode_reg[2:0] == dsim_pkg::BL_CODE_8 |-> cur_col[2:0] == start_reg[2:0] + beat_reg)
		else $error("sequential order wrong");

	chk_order_ilv: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		(burst_reg == BST_WR || burst_reg == BST_RD) && mode_reg[dsim_pkg::BT_BIT]
		&& mode_reg[2:0] == dsim_pkg::BL_CODE_8 |-> cur_col[2:0] == (start_reg[2:0] ^ beat_reg))
		else $error("interleaved order wrong");

	chk_lock_count: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		mode_reg[dsim_pkg::DLL_RST_BIT] |=> lock_reg == dsim_pkg::DLL_LOCK_CYC ##1 !dll_on_out)
		else $error("DLL lock count not started");

endmodule

/* File: hdl/dsim_pkg.sv */
/*
 * Shared constants and types for the DDR SDRAM command, mode and burst core.
 * Assumes one clock shared with the memory controller; the controller's command
 * and data pins are registered logic on that same clock.
 */
package dsim_pkg;

	localparam int          DQ_W          = 8;
	localparam int          COL_W         = 4;

	// command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0]  CMD_MRS       = 4'h0;
	localparam logic [3:0]  CMD_REF       = 4'h1;
	localparam logic [3:0]  CMD_PRE       = 4'h2;
	localparam logic [3:0]  CMD_ACT       = 4'h3;
	localparam logic [3:0]  CMD_WR        = 4'h4;
	localparam logic [3:0]  CMD_RD        = 4'h5;

	// mode register select by bank bits
	localparam logic [1:0]  BA_MODE       = 2'h0;
	localparam logic [1:0]  BA_EXT_MODE   = 2'h1;

	// mode register field positions
	localparam int          BL_LSB        = 0;
	localparam int          BT_BIT        = 3;
	localparam int          CL_LSB        = 4;
	localparam int          OPMODE_LSB    = 7;
	localparam int          DLL_RST_BIT   = 8;
	localparam int          EXT_DLL_BIT   = 0;
	localparam int          PRE_ALL_BIT   = 10;

	// field codes
	localparam logic [2:0]  BL_CODE_2     = 3'h1;
	localparam logic [2:0]  BL_CODE_4     = 3'h2;
	localparam logic [2:0]  BL_CODE_8     = 3'h3;
	localparam logic [2:0]  CL_CODE_2     = 3'h2;
	localparam logic [2:0]  CL_CODE_3     = 3'h3;
	localparam logic [2:0]  CL_CODE_25    = 3'h5;
	localparam logic [5:0]  OPMODE_NORMAL = 6'h00;
	localparam logic [5:0]  OPMODE_DLLRST = 6'h02;

	// reset values
	localparam logic [12:0] MODE_RESET    = 13'h0000;
	localparam logic [12:0] EXT_RESET     = 13'h0001;

	// timing counts in clock cycles
	localparam logic [7:0]  DLL_LOCK_CYC  = 8'hC8;

	typedef struct packed {
		logic        cke;
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [1:0]  ba;
		logic [12:0] addr;
	} dsim_cmd_s;

	typedef struct packed {
		logic [DQ_W-1:0] rise;
		logic [DQ_W-1:0] fall;
	} dsim_pair_s;

	typedef enum logic [1:0] {
		BST_IDLE,
		BST_RD_WAIT,
		BST_RD,
		BST_WR
	} dsim_burst_e;

	typedef enum logic [3:0] {
		INI_PRE1,
		INI_EXT,
		INI_DLLRST,
		INI_LOCK,
		INI_PRE2,
		INI_REF1,
		INI_REF2,
		INI_MODE,
		INI_DONE
	} dsim_init_e;

endpackage

/* File: tb/dsim_ctrl_model.sv */
/*
 * Memory controller model: power-up sequence, mode loads, commands and write bursts.
 * Assumes the device samples every pin on the rising edge of clk_in.
 */
`timescale 1ns/1ps
module dsim_ctrl_model
#(
	parameter int PWRUP_CYC = 8000 // 200 us at 40 MHz
)
(
	input  wire logic            clk_in,   // shared clock
	output dsim_pkg::dsim_cmd_s  cmd_out,  // command, bank and address pins
	output dsim_pkg::dsim_pair_s dq_out,   // write data halves
	output logic [1:0]           dm_out,   // write mask
	output logic                 stall_out // read hold-off
);
	initial
	begin
		cmd_out   = {1'b0, 4'hF, 2'h0, 13'h1FFF};
		dq_out    = 16'h0F0F;
		dm_out    = 2'h0;
		stall_out = 1'b0;
	end

	task automatic issue(input logic [3:0] code, input logic [1:0] ba, input logic [12:0] addr);
		@(posedge clk_in);
		cmd_out <= {1'b1, code, ba, addr};
		@(posedge clk_in);
		// deselect; the address lines no longer hold the old value
		cmd_out <= {1'b1, 4'hF, ba, ~addr};
	endtask

	task automatic set_stall(input logic v);
		stall_out <= v;
	endtask

	task automatic set_mask(input logic [1:0] m);
		dm_out <= m;
	endtask

	task automatic load_mode(input logic [12:0] m);
		issue(dsim_pkg::CMD_PRE, 2'h0, 13'h0400);
		issue(dsim_pkg::CMD_MRS, dsim_pkg::BA_MODE, m);
	endtask

	task automatic init_seq(input logic [12:0] m);
		repeat (PWRUP_CYC) @(posedge clk_in);
		cmd_out <= {1'b1, 4'hF, 2'h0, 13'h0000};
		issue(dsim_pkg::CMD_PRE, 2'h0, 13'h0400);
		issue(dsim_pkg::CMD_MRS, dsim_pkg::BA_EXT_MODE, 13'h0000);
		issue(dsim_pkg::CMD_MRS, dsim_pkg::BA_MODE, m | 13'h0100);
		repeat (200) @(posedge clk_in);
		issue(dsim_pkg::CMD_PRE, 2'h0, 13'h0400);
		repeat (2) issue(dsim_pkg::CMD_REF, 2'h0, 13'h0000);
		issue(dsim_pkg::CMD_MRS, dsim_pkg::BA_MODE, m);
	endtask

	task automatic write_burst(input logic [1:0] ba, input logic [12:0] col, input int n,
		input dsim_pkg::dsim_pair_s w [8]);
		@(posedge clk_in);
		cmd_out <= {1'b1, dsim_pkg::CMD_WR, ba, col};
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_in);
			if (i == 0)
				cmd_out <= {1'b1, 4'hF, ba, ~col};
			dq_out <= w[i];
		end
		@(posedge clk_in);
		dq_out <= ~w[n - 1];
	endtask
endmodule

/* File: tb/testbench.sv */
/*
 * Self-checking bench for the DDR SDRAM core: init, mode fields, burst order,
 * read latency, reserved codes and a stalled read.
 * Assumes the controller model drives the command, data, mask and stall inputs on the same clock; the bench drives reset.
 */
`timescale 1ns/1ps
module testbench;
	logic                 ref_clk_in;
	logic                 reset_n_in;
	dsim_pkg::dsim_cmd_s  cmd;
	dsim_pkg::dsim_pair_s dq_w;
	dsim_pkg::dsim_pair_s dq_r;
	logic [1:0]           dm;
	logic                 stall;
	logic                 rd_ready;
	logic                 dq_oe;
	logic [1:0]           dqs;
	logic                 dqs_oe;
	logic [12:0]          mode_cfg;
	logic                 dll_on;
	logic                 init_done;
	logic                 cfg_res;
	int                   err_count = 0;
	int                   checks = 0;
	int                   cyc = 0;
	int                   a8_cnt = 0;

	dsim_ctrl_model dsim_ctrl_model_i (.clk_in(ref_clk_in), .cmd_out(cmd), .dq_out(dq_w),
		.dm_out(dm), .stall_out(stall));

	dsim_core dsim_core_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cmd_in(cmd),
		.dq_in(dq_w), .dm_in(dm), .rd_stall_in(stall), .rd_ready_out(rd_ready),
		.dq_out(dq_r), .dq_oe_out(dq_oe), .dqs_out(dqs), .dqs_oe_out(dqs_oe),
		.mode_cfg_out(mode_cfg), .dll_on_out(dll_on), .init_done_out(init_done),
		.cfg_reserved_out(cfg_res));

	initial
	begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end

	task automatic conclude();
		$display("checks %0d, errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// the whole run needs about 8900 cycles
	always @(posedge ref_clk_in)
	begin
		cyc++;
		if (mode_cfg[8] === 1'b1)
			a8_cnt++;
		if (cyc == 20000)
		begin
			err_count++;
			conclude();
		end
	end

	function automatic dsim_pkg::dsim_pair_s col_word(input logic [3:0] c);
		return {4'hA, c, 4'h5, c};
	endfunction

	task automatic load(input logic [12:0] m, input logic res);
		dsim_ctrl_model_i.load_mode(m);
		#1 chk("mode_cfg", {3'h0, m}, {3'h0, mode_cfg});
		@(posedge ref_clk_in);
		#1 chk("cfg_reserved", {15'h0, res}, {15'h0, cfg_res});
		dsim_ctrl_model_i.issue(dsim_pkg::CMD_ACT, 2'h1, 13'h0002);
	endtask

	task automatic rd(input logic [3:0] s, input int len, input logic ilv, input int lat,
		input int exp_n, input logic hold);
		int n;
		int blk;
		logic [3:0] c;
		n = 0;
		blk = s & ~(len - 1);
		dsim_ctrl_model_i.issue(dsim_pkg::CMD_RD, 2'h1, {9'h000, s});
		dsim_ctrl_model_i.set_stall(hold);
		for (int k = 1; k <= 30; k++)
		begin
			@(posedge ref_clk_in);
			if (k == 8)
				dsim_ctrl_model_i.set_stall(1'b0);
			#1 chk("strobe_oe", {15'h0, dq_oe}, {15'h0, dqs_oe});
			if (hold && k == 7)
				chk("rd_ready_full", 16'h0000, {15'h0, rd_ready});
			if (dq_oe === 1'b1)
			begin
				if (n == 0 && !hold)
					chk("latency", lat[15:0], k[15:0]);
				c = 4'(ilv ? blk | ((s ^ n) & (len - 1)) : blk | ((s + n) & (len - 1)));
				chk("rd_word", col_word(c), dq_r);
				chk("strobe", 16'h0002, {14'h0, dqs});
				n++;
			end
		end
		chk("beats", exp_n[15:0], n[15:0]);
	endtask

	task automatic fill();
		dsim_pkg::dsim_pair_s w [8];
		load(13'h0023, 1'b0);
		for (int b = 0; b < 2; b++)
		begin
			for (int i = 0; i < 8; i++)
				w[i] = col_word(4'(b * 8 + i));
			dsim_ctrl_model_i.write_burst(2'h1, 13'(b * 8), 8, w);
		end
		// a fully masked burst of zeros must leave the first block intact
		for (int i = 0; i < 8; i++)
			w[i] = '0;
		dsim_ctrl_model_i.set_mask(2'h3);
		dsim_ctrl_model_i.write_burst(2'h1, 13'h0000, 8, w);
		dsim_ctrl_model_i.set_mask(2'h0);
	endtask

	task automatic sweep();
		for (int lc = 1; lc <= 3; lc++)
			for (int t = 0; t < 2; t++)
			begin
				load({6'h00, t[0] ? 3'h5 : 3'h2, t[0], lc[2:0]}, 1'b0);
				rd(4'h3, 1 << lc, t[0], t + 2, 1 << lc, 1'b0);
				rd(4'hD, 1 << lc, t[0], t + 2, 1 << lc, 1'b0);
			end
		// receiver stalls long enough to fill the two-entry buffer
		rd(4'hD, 8, 1'b1, 3, 8, 1'b1);
		chk("rd_ready", 16'h0001, {15'h0, rd_ready});
		chk("mode_kept", 16'h005B, {3'h0, mode_cfg});
	endtask

	task automatic reserved();
		logic [12:0] tbl [4];
		tbl = '{13'h0020, 13'h0027, 13'h0012, 13'h00A2};
		for (int i = 0; i < 4; i++)
		begin
			load(tbl[i], 1'b1);
			rd(4'h0, 4, 1'b0, 2, i == 3 ? 4 : 0, 1'b0);
		end
		load(13'h0023, 1'b0);
	endtask

	initial
	begin
		reset_n_in = 1'b0;
		repeat (8) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		@(posedge ref_clk_in);
		#1 chk("mode_rst", 16'h0000, {3'h0, mode_cfg});
		chk("dq_oe_rst", 16'h0000, {15'h0, dq_oe});
		chk("rd_ready_rst", 16'h0001, {15'h0, rd_ready});
		dsim_ctrl_model_i.init_seq(13'h0023);
		@(posedge ref_clk_in);
		#1 chk("init_done", 16'h0001, {15'h0, init_done});
		chk("dll_on", 16'h0001, {15'h0, dll_on});
		chk("dll_rst_pulse", 16'h0001, a8_cnt[15:0]);
		chk("mode_after_init", 16'h0023, {3'h0, mode_cfg});
		chk("dq_oe_idle", 16'h0000, {15'h0, dq_oe});
		fill();
		sweep();
		reserved();
		conclude();
	end
endmodule
